// ===== hw/evp_pkg.sv
// Purpose: Constants and state type of the exception vector and priority unit
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Offsets are byte addresses of aligned words
package evp_pkg;
	localparam int          NUM_IRQ      = 57;          // Slots 0x82..0xF2, step two
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  VBR_OFF      = 8'h00;       // Vector base register
	localparam logic [7:0]  STAT_OFF     = 8'h04;       // Last vector, pending summary
	localparam logic [7:0]  VBR_RST      = 8'hFF;
	localparam logic [7:0]  DBG_BASE     = 8'hFF;
	localparam logic [7:0]  LOW_SPUR     = 8'h80;
	localparam logic [7:0]  LOW_IRQ0     = 8'h82;
	localparam logic [7:0]  LOW_XIRQ     = 8'hF4;
	localparam logic [7:0]  LOW_SWI      = 8'hF6;
	localparam logic [7:0]  LOW_TRAP     = 8'hF8;
	localparam logic [15:0] VEC_POR      = 16'hFFFE;
	localparam logic [15:0] VEC_CLKMON   = 16'hFFFC;
	localparam logic [15:0] VEC_COP      = 16'hFFFA;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
	localparam int          STAT_PEND_LSB = 16;

	// Whole state of the unit, registered in one process
	typedef struct packed {
		logic [7:0]        vbr;
		logic              aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_have;
		logic [31:0]       w_data;
		logic              w_strb0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [15:0]       vec;
		logic              vec_ack;
		logic              wake;
	} evp_state_t;
endpackage

// ===== hw/evp_unit.sv
// Purpose: Exception vector and priority unit with AXI4-Lite register access
// Assumes: Requests and CPU handshakes synchronous to clk_sys_i
// Notes:   Clock must stay running in wait and stop so the wake-up flop can act
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module evp_unit
(
	input  wire logic                           clk_sys_i,
	input  wire logic                           resetn_i,
	// Exception sources, internal only
	input  wire logic [evp_pkg::NUM_IRQ-1:0]    irq_req_i,
	input  wire logic                           xirq_req_i,
	input  wire logic                           soft_interrupt_request_i,
	input  wire logic                           trap_req_i,
	input  wire logic                           rst_por_i,
	input  wire logic                           rst_clkmon_i,
	input  wire logic                           rst_cop_i,
	// CPU side
	input  wire logic [1:0]                     cpu_condition_flags_i,
	input  wire logic                           debug_freeze_state_i,
	input  wire logic                           wait_mode_i,
	input  wire logic                           stop_mode_i,
	input  wire logic                           vec_req_i,
	output logic [15:0]                         vec_o,
	output logic                                vec_ack_o,
	output logic                                wakeup_o,
	// AXI4-Lite slave
	input  wire logic [evp_pkg::ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [evp_pkg::ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready
);
	evp_pkg::evp_state_t st_r;
	evp_pkg::evp_state_t st_nxt;
	logic                          imask;
	logic                          xmask;
	logic [evp_pkg::NUM_IRQ-1:0]   irq_live;
	logic                          irq_any;
	logic [5:0]                    irq_top;
	logic                          rst_any;
	logic [7:0]                    base;
	logic [15:0]                   vec_sel;
	logic                          wr_fire;
	logic                          rd_fire;

	// Word-aligned byte address (low two bits cleared) of an AXI byte address, shared by both channels
	function automatic logic [evp_pkg::ADDR_W-1:0] word_of(input logic [evp_pkg::ADDR_W-1:0] a);
		word_of = {a[evp_pkg::ADDR_W-1:2], 2'b00};
	endfunction

	// Mask bits from the CPU flags: bit 0 I mask, bit 1 X mask
	assign imask = cpu_condition_flags_i[0];
	assign xmask = cpu_condition_flags_i[1];

	// Live maskable requests; priorities fixed by slot position
	generate
		for (genvar g = 0; g < evp_pkg::NUM_IRQ; g++)
		begin : g_live
			assign irq_live[g] = irq_req_i[g] & ~imask;
		end
	endgenerate

	assign irq_any = |irq_live;
	assign rst_any = rst_por_i | rst_clkmon_i | rst_cop_i;

	// Highest slot index pending, i.e. highest vector address
	always_comb
	begin
		irq_top = 6'd0;
		for (int i = 0; i < evp_pkg::NUM_IRQ; i++)
		begin
			if (irq_live[i])
			begin
				irq_top = 6'(i);
			end
		end
	end

	// Base byte, forced high while debug firmware runs
	assign base = debug_freeze_state_i ? evp_pkg::DBG_BASE : st_r.vbr;

	// Priority decode, from resets down to spurious
	always_comb
	begin
		if (rst_por_i)
		begin
			vec_sel = evp_pkg::VEC_POR;
		end
		else if (rst_clkmon_i)
		begin
			vec_sel = evp_pkg::VEC_CLKMON;
		end
		else if (rst_cop_i)
		begin
			vec_sel = evp_pkg::VEC_COP;
		end
		else if (trap_req_i)
		begin
			vec_sel = {base, evp_pkg::LOW_TRAP};
		end
		else if (soft_interrupt_request_i)
		begin
			vec_sel = {base, evp_pkg::LOW_SWI};
		end
		else if (xirq_req_i && !xmask)
		begin
			vec_sel = {base, evp_pkg::LOW_XIRQ};
		end
		else if (irq_any)
		begin
			vec_sel = {base, 8'(evp_pkg::LOW_IRQ0 + {irq_top, 1'b0})};
		end
		else
		begin
			vec_sel = {base, evp_pkg::LOW_SPUR};
		end
	end

	assign wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;
	assign rd_fire = s_axi_arvalid && st_r.arready;

	// Next state: vector handshake, wake-up and register bus
	always_comb
	begin
		st_nxt = st_r;
		// Vector only sampled on the CPU's request
		st_nxt.vec_ack = vec_req_i;
		if (vec_req_i)
		begin
			st_nxt.vec = vec_sel;
		end
		// Wake-up while the core sleeps
		st_nxt.wake = (wait_mode_i || stop_mode_i) && (rst_any || trap_req_i
			|| soft_interrupt_request_i || (xirq_req_i && !xmask) || irq_any);
		// Write address and data taken in either order
		if (s_axi_awvalid && st_r.awready)
		begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = word_of(s_axi_awaddr);
		end
		if (s_axi_wvalid && st_r.wready)
		begin
			st_nxt.w_have  = 1'b1;
			st_nxt.w_data  = s_axi_wdata;
			st_nxt.w_strb0 = s_axi_wstrb[0];
		end
		if (wr_fire)
		begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = evp_pkg::RESP_SLVERR;
			if (st_r.aw_addr == evp_pkg::VBR_OFF)
			begin
				st_nxt.bresp = evp_pkg::RESP_OKAY;
				if (st_r.w_strb0)
				begin
					st_nxt.vbr = st_r.w_data[7:0];
				end
			end
			else if (st_r.aw_addr == evp_pkg::STAT_OFF)
			begin
				st_nxt.bresp = evp_pkg::RESP_OKAY; // Read-only, write ignored
			end
		end
		if (st_r.bvalid && s_axi_bready)
		begin
			st_nxt.bvalid = 1'b0;
		end
		st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;
		// Read channel, one outstanding
		if (rd_fire)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = evp_pkg::RESP_OKAY;
			st_nxt.rdata  = 32'h0000_0000;
			if (word_of(s_axi_araddr) == evp_pkg::VBR_OFF)
			begin
				st_nxt.rdata[7:0] = st_r.vbr;
			end
			else if (word_of(s_axi_araddr) == evp_pkg::STAT_OFF)
			begin
				st_nxt.rdata[15:0] = st_r.vec;
				st_nxt.rdata[evp_pkg::STAT_PEND_LSB]   = irq_any;
				st_nxt.rdata[evp_pkg::STAT_PEND_LSB+1] = xirq_req_i && !xmask;
				st_nxt.rdata[evp_pkg::STAT_PEND_LSB+2] = debug_freeze_state_i;
			end
			else
			begin
				st_nxt.rresp = evp_pkg::RESP_SLVERR;
			end
		end
		else if (st_r.rvalid && s_axi_rready)
		begin
			st_nxt.rvalid = 1'b0;
		end
		st_nxt.arready = !st_nxt.rvalid;
	end

	// State register, base loads 0xFF at reset
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_r         <= '0;
			st_r.vbr     <= evp_pkg::VBR_RST;
			st_r.awready <= 1'b1;
			st_r.wready  <= 1'b1;
			st_r.arready <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops; no external pins
	assign vec_o         = st_r.vec;
	assign vec_ack_o     = st_r.vec_ack;
	assign wakeup_o      = st_r.wake;
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rresp   = st_r.rresp;
	assign s_axi_rdata   = st_r.rdata;

	// Checks on the vector path, wake-up in wait and register bus
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	a_ack_after_req: assert property (vec_req_i |=> vec_ack_o)
		else $error("vector ack not one cycle after request");
	a_no_ack_idle: assert property (!vec_req_i |=> !vec_ack_o)
		else $error("vector ack without request");
	a_por_vector: assert property (vec_req_i && rst_por_i |=> vec_o == 16'hFFFE)
		else $error("power-on reset vector wrong");
	a_trap_vector: assert property (vec_req_i && !rst_any && trap_req_i
		|=> vec_o[7:0] == 8'hF8 && vec_o[15:8] == $past(base))
		else $error("trap vector wrong");
	a_debug_base: assert property (vec_req_i && !rst_any && debug_freeze_state_i
		|=> vec_o[15:8] == 8'hFF)
		else $error("debug base not forced");
	a_spur_vector: assert property (vec_req_i && !rst_any && !trap_req_i
		&& !soft_interrupt_request_i && !(xirq_req_i && !xmask) && !irq_any
		|=> vec_o[7:0] == 8'h80)
		else $error("spurious vector wrong");
	a_top_irq_wins: assert property (vec_req_i && !rst_any && !trap_req_i
		&& !soft_interrupt_request_i && !(xirq_req_i && !xmask) && irq_req_i[56] && !imask
		|=> vec_o[7:0] == 8'hF2)
		else $error("highest maskable request lost");
	a_xirq_masked: assert property (vec_req_i && xmask && !rst_any && !trap_req_i
		&& !soft_interrupt_request_i |=> vec_o[7:0] != 8'hF4)
		else $error("masked X request granted");
	a_wake_wait: assert property (wait_mode_i && irq_any |=> wakeup_o)
		else $error("no wake-up in wait");
	a_base_write: assert property (wr_fire && st_r.aw_addr == 8'h00 && st_r.w_strb0
		|=> st_r.vbr == $past(st_r.w_data[7:0]) && s_axi_bvalid)
		else $error("base register not written");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	// Stop-mode wake-up and base value right after reset
	a_wake_stop: assert property (stop_mode_i && xirq_req_i && !xmask |=> wakeup_o)
		else $error("no wake-up in stop");
	a_base_reset: assert property ($rose(resetn_i) |-> st_r.vbr == evp_pkg::VBR_RST)
		else $error("base not 0xFF after reset");
endmodule

// ===== bench/evp_cpu_model.sv
// Purpose: CPU side model that fetches exception vectors
// Assumes: Answer is registered, one cycle after the request edge
// Notes:   Request is a single-cycle pulse per fetch
`timescale 1ns/1ps
module evp_cpu_model
(
	input  wire logic        clk_i,
	input  wire logic [15:0] vec_i,
	input  wire logic        ack_i,
	output logic             req_o
);
	// Idle until the bench asks for a vector
	initial req_o = 1'b0;

	// One vector fetch, answer taken one cycle after the request edge
	task automatic fetch(output logic [15:0] v, output logic a);
		@(posedge clk_i);
		req_o <= 1'b1;
		@(posedge clk_i);
		req_o <= 1'b0;
		#1;
		v = vec_i;
		a = ack_i;
	endtask
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench for the exception vector and priority unit
// Assumes: Vectors fetched by the CPU model, registers over AXI4-Lite
// Notes:   Random sources come from a fixed seed
`timescale 1ns/1ps
module tb;
	logic        clk_sys_i, resetn_i, vec_req_i, vec_ack_o, wakeup_o, xirq_req_i;
	logic        soft_interrupt_request_i, trap_req_i, rst_por_i, rst_clkmon_i, rst_cop_i;
	logic        debug_freeze_state_i, wait_mode_i, stop_mode_i, s_axi_awvalid, s_axi_awready;
	logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]  cpu_condition_flags_i, s_axi_bresp, s_axi_rresp, rsp;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, base;
	logic [15:0] vec_o;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [56:0] irq_req_i;
	int          failures, n_compared;

	evp_unit i_evp_unit (.clk_sys_i, .resetn_i, .irq_req_i, .xirq_req_i,
		.soft_interrupt_request_i, .trap_req_i, .rst_por_i, .rst_clkmon_i, .rst_cop_i,
		.cpu_condition_flags_i, .debug_freeze_state_i, .wait_mode_i, .stop_mode_i, .vec_req_i,
		.vec_o, .vec_ack_o, .wakeup_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	evp_cpu_model i_evp_cpu_model (.clk_i(clk_sys_i), .vec_i(vec_o), .ack_i(vec_ack_o),
		.req_o(vec_req_i));

	// 200 MHz clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("failures=%0d compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Write one word, address and data offered together; bready raised once bvalid shows
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk_sys_i);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		forever
		begin
			@(posedge clk_sys_i);
			if (s_axi_bready && s_axi_bvalid)
			begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
	endtask

	// Read one word into rd and rsp
	task automatic axr(input logic [7:0] a);
		logic ta;
		ta = 1'b0;
		@(posedge clk_sys_i);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever
		begin
			@(posedge clk_sys_i);
			if (ta && s_axi_rvalid)
			begin
				rd  = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
			ta = ta | s_axi_arready;
			if (ta) s_axi_arvalid <= 1'b0;
		end
	endtask

	// Expected vector; nm is {trap, soft, x}
	function automatic logic [15:0] exp_vec(input logic [2:0] rs, input logic [2:0] nm,
		input logic [56:0] iq, input logic [1:0] fl, input logic fz);
		logic [7:0] hb;
		hb = fz ? 8'hFF : base;
		exp_vec = {hb, 8'h80};
		for (int i = 0; i < 57; i++)
			if (iq[i] && !fl[0]) exp_vec = {hb, 8'(8'h82 + 2 * i)};
		if (nm[0] && !fl[1]) exp_vec = {hb, 8'hF4};
		if (nm[1]) exp_vec = {hb, 8'hF6};
		if (nm[2]) exp_vec = {hb, 8'hF8};
		if (rs[2]) exp_vec = 16'hFFFA;
		if (rs[1]) exp_vec = 16'hFFFC;
		if (rs[0]) exp_vec = 16'hFFFE;
	endfunction

	// Drive sources, fetch a vector, compare
	task automatic run_vec(input logic [2:0] rs, input logic [2:0] nm, input logic [56:0] iq,
		input logic [1:0] fl, input logic fz);
		logic [15:0] v;
		logic        a;
		{rst_cop_i, rst_clkmon_i, rst_por_i} <= rs;
		{trap_req_i, soft_interrupt_request_i, xirq_req_i} <= nm;
		irq_req_i             <= iq;
		cpu_condition_flags_i <= fl;
		debug_freeze_state_i  <= fz;
		i_evp_cpu_model.fetch(v, a);
		chk(32'(a), 32'h0000_0001);
		chk(32'(v), 32'(exp_vec(rs, nm, iq, fl, fz)));
	endtask

	// Sleep mode and sources for one cycle, then check wake-up
	task automatic wk(input logic [1:0] m, input logic [1:0] fl, input logic xr,
		input logic [56:0] iq, input logic e);
		@(posedge clk_sys_i);
		{stop_mode_i, wait_mode_i} <= m;
		cpu_condition_flags_i      <= fl;
		xirq_req_i                 <= xr;
		irq_req_i                  <= iq;
		@(posedge clk_sys_i);
		#1;
		chk(32'(wakeup_o), 32'(e));
	endtask

	// Watchdog
	initial
	begin
		#300000;
		failures++;
		finish_test();
	end

	// Main sequence
	initial
	begin
		{resetn_i, xirq_req_i, soft_interrupt_request_i, trap_req_i, rst_por_i} = '0;
		{rst_clkmon_i, rst_cop_i, debug_freeze_state_i, wait_mode_i, stop_mode_i} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		irq_req_i = '0;
		cpu_condition_flags_i = 2'b11;
		failures = 0;
		n_compared = 0;
		base = 8'hFF;
		void'($urandom(17601));
		repeat (2) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		axr(8'h00);
		chk(rd, 32'h0000_00FF);
		run_vec(3'b000, 3'b000, 57'h0, 2'b00, 1'b0);
		run_vec(3'b111, 3'b111, '1, 2'b00, 1'b0);
		run_vec(3'b110, 3'b111, '1, 2'b00, 1'b0);
		run_vec(3'b100, 3'b111, '1, 2'b00, 1'b0);
		run_vec(3'b000, 3'b111, '1, 2'b00, 1'b0);
		run_vec(3'b000, 3'b011, '1, 2'b11, 1'b0);
		run_vec(3'b000, 3'b001, '1, 2'b00, 1'b0);
		run_vec(3'b000, 3'b001, '1, 2'b10, 1'b0);
		run_vec(3'b000, 3'b000, 57'h1, 2'b00, 1'b0);
		run_vec(3'b000, 3'b000, 57'h1, 2'b01, 1'b0);
		base = 8'h3C;
		axw(8'h00, 32'hA5A5_A53C, 4'hF);
		chk(32'(rsp), 32'h0000_0000);
		axw(8'h00, 32'h0000_0011, 4'h0);
		axr(8'h00);
		chk(rd, 32'h0000_003C);
		axw(8'h40, 32'h0000_0011, 4'hF);
		chk(32'(rsp), 32'h0000_0002);
		axr(8'h40);
		chk(32'(rsp), 32'h0000_0002);
		run_vec(3'b000, 3'b000, 57'h400, 2'b00, 1'b0);
		run_vec(3'b000, 3'b010, 57'h0, 2'b00, 1'b1);
		run_vec(3'b001, 3'b000, 57'h0, 2'b00, 1'b0);
		for (int k = 0; k < 60; k++)
		begin
			if (k % 10 == 0)
			begin
				base = 8'($urandom);
				axw(8'h00, {24'h0, base}, 4'hF);
			end
			run_vec(($urandom % 6 == 0) ? 3'($urandom) : 3'b000, 3'($urandom & $urandom),
				57'({$urandom, $urandom} & {$urandom, $urandom}), 2'($urandom),
				$urandom % 4 == 0);
		end
		run_vec(3'b000, 3'b000, 57'h0, 2'b00, 1'b0);
		axr(8'h04);
		chk(rd, {16'h0000, base, 8'h80});
		axw(8'h04, 32'hFFFF_FFFF, 4'hF);
		chk(32'(rsp), 32'h0000_0000);
		axr(8'h00);
		chk(rd, {24'h00_0000, base});
		wk(2'b01, 2'b00, 1'b0, 57'h4, 1'b1);
		wk(2'b01, 2'b01, 1'b0, 57'h4, 1'b0);
		wk(2'b00, 2'b00, 1'b1, '1, 1'b0);
		wk(2'b10, 2'b11, 1'b1, 57'h0, 1'b0);
		wk(2'b10, 2'b01, 1'b1, 57'h0, 1'b1);
		// Mid-run reset: base must return to 0xFF
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		base = 8'hFF;
		axr(8'h00);
		chk(rd, 32'h0000_00FF);
		run_vec(3'b000, 3'b000, 57'h0, 2'b00, 1'b0);
		finish_test();
	end
endmodule
